//--- rtl/gei_dev.sv
// Expander end: serial slave, register file and change-detect interrupt.
// Summary of operation
// - Unmasked input pin change pulls interrupt low.
// - Interrupt releases on pin return or input read.
// - Input register read or pin return clears the interrupt.
// - Change detector compares against stored input image.
// - Master sets mask and direction at start-up.
// - Standby while bus idle, resume on activity.
// - Master starts only with both lines high.
// - One bit per clock, data stable while high.
// - START is SDA falling while SCL high.
// - STOP is SDA rising while SCL high.
// - Every byte followed by one acknowledge bit.
// - Receiving slave holds SDA low during acknowledge; the device acks only address, command and the first data byte.
// - Master clocks acknowledge, transmitter releases SDA.
// - Master acknowledges every read byte but last.
// - No acknowledge on last byte, slave releases.
// - Write Byte writes, Read Byte reads registers.
// - Mask bit zero enables, all set at reset.
// - Direction bit one is input, reset inputs.
// - Status reads zero for masked pins.
module gei_dev
  import gei_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEV_ADDR
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  gei_if.dev bus,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOeN,
  output logic standby
);
  typedef struct packed {
    gei_dst_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic rdDir;
    logic mAck;
    logic sdaOeN;
    logic [7:0] cfg;
    logic [7:0] outp;
    logic [7:0] mask;
    logic [7:0] image;
    logic intOeN;
    logic standby;
  } gei_dev_t;
  gei_dev_t s_q, s_d;

  logic sclLvl;
  logic sclRise;
  logic sclFall;
  logic sdaLvl;
  logic sdaRise;
  logic sdaFall;
  logic [7:0] pinLvl;
  logic startCond;
  logic stopCond;
  logic [7:0] change;
  logic [7:0] rdVal;

  gei_sync #(.W(1), .INIT(1'b1)) sclSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(bus.scl),
    .lvl(sclLvl),
    .rise(sclRise),
    .fall(sclFall)
  );

  gei_sync #(.W(1), .INIT(1'b1)) sdaSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(bus.sda),
    .lvl(sdaLvl),
    .rise(sdaRise),
    .fall(sdaFall)
  );

  gei_sync #(.W(8), .INIT(8'h00)) pinSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(pinIn),
    .lvl(pinLvl),
    .rise(),
    .fall()
  );

  assign startCond = sclLvl & sdaFall;
  assign stopCond = sclLvl & sdaRise;

  // A bit is set while an enabled input differs from the last image read.
  assign change = (pinLvl ^ s_q.image) & s_q.cfg & ~s_q.mask;

  always_comb begin
    if (s_q.cmd == REG_IN) begin
      rdVal = pinLvl;
    end else if (s_q.cmd == REG_CFG) begin
      rdVal = s_q.cfg;
    end else if (s_q.cmd == REG_OUT) begin
      rdVal = s_q.outp;
    end else if (s_q.cmd == REG_MASK) begin
      rdVal = s_q.mask;
    end else if (s_q.cmd == REG_STAT) begin
      rdVal = change;
    end else begin
      rdVal = 8'h00;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.intOeN = ~|change;
    if (startCond) begin
      // A repeated START restarts address reception from any state.
      s_d.st = D_ADDR;
      s_d.bitCnt = 4'h0;
      s_d.sdaOeN = 1'b1;
      s_d.standby = 1'b0;
    end else if (stopCond) begin
      s_d.st = D_IDLE;
      s_d.sdaOeN = 1'b1;
      s_d.standby = 1'b1;
    end else begin
      case (s_q.st)
        D_ADDR, D_CMD, D_WDATA: begin
          if (sclRise) begin
            s_d.shift = {s_q.shift[6:0], sdaLvl};
            s_d.bitCnt = s_q.bitCnt + 4'h1;
          end
          if (sclFall && s_q.bitCnt == 4'h8) begin
            s_d.bitCnt = 4'h0;
            s_d.st = D_IGNORE;
            if (s_q.st == D_ADDR) begin
              if (s_q.shift[7:1] == SLAVE_ADDR) begin
                s_d.rdDir = s_q.shift[0];
                s_d.sdaOeN = 1'b0;
                s_d.st = D_AACK;
              end
            end else if (s_q.st == D_CMD) begin
              s_d.cmd = s_q.shift;
              s_d.sdaOeN = 1'b0;
              s_d.st = D_CACK;
            end else begin
              if (s_q.cmd == REG_CFG) begin
                s_d.cfg = s_q.shift;
              end else if (s_q.cmd == REG_OUT) begin
                s_d.outp = s_q.shift;
              end else if (s_q.cmd == REG_MASK) begin
                s_d.mask = s_q.shift;
              end
              s_d.sdaOeN = 1'b0;
              s_d.st = D_WACK;
            end
          end
        end
        D_AACK: begin
          if (sclFall) begin
            s_d.sdaOeN = 1'b1;
            if (s_q.rdDir) begin
              s_d.shift = rdVal;
              s_d.sdaOeN = rdVal[7];
              s_d.st = D_TX;
              if (s_q.cmd == REG_IN) begin
                s_d.image = pinLvl;
              end
            end else begin
              s_d.st = D_CMD;
            end
          end
        end
        D_CACK: begin
          if (sclFall) begin
            s_d.sdaOeN = 1'b1;
            s_d.st = D_WDATA;
          end
        end
        D_WACK: begin
          // Bytes beyond the single data byte are not acknowledged.
          if (sclFall) begin
            s_d.sdaOeN = 1'b1;
            s_d.st = D_IGNORE;
          end
        end
        D_TX: begin
          if (sclRise) begin
            s_d.bitCnt = s_q.bitCnt + 4'h1;
          end
          if (sclFall) begin
            if (s_q.bitCnt == 4'h8) begin
              s_d.sdaOeN = 1'b1;
              s_d.bitCnt = 4'h0;
              s_d.st = D_MACK;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.sdaOeN = s_q.shift[6];
            end
          end
        end
        D_MACK: begin
          if (sclRise) begin
            s_d.mAck = ~sdaLvl;
          end
          if (sclFall) begin
            if (s_q.mAck) begin
              s_d.shift = rdVal;
              s_d.sdaOeN = rdVal[7];
              s_d.st = D_TX;
              if (s_q.cmd == REG_IN) begin
                s_d.image = pinLvl;
              end
            end else begin
              s_d.st = D_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{st: D_IDLE, bitCnt: 4'h0, shift: 8'h00, cmd: 8'h00, rdDir: 1'b0,
               mAck: 1'b0, sdaOeN: 1'b1, cfg: CFG_RST, outp: OUT_RST,
               mask: MASK_RST, image: IMAGE_RST, intOeN: 1'b1, standby: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign pinOut = s_q.outp;
  assign pinOeN = s_q.cfg;
  assign standby = s_q.standby;
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOeN = s_q.sdaOeN;
  assign bus.devIntOut = 1'b0;
  assign bus.devIntOeN = s_q.intOeN;
endmodule

//--- rtl/gei_pkg.sv
// Shared constants and state types of the GPIO expander serial link.
package gei_pkg;
  // Expander register indices, selected by the command byte.
  localparam logic [7:0] REG_IN = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_OUT = 8'h05;
  localparam logic [7:0] REG_MASK = 8'h06;
  localparam logic [7:0] REG_STAT = 8'h07;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] IMAGE_RST = 8'h00;
  // Default seven-bit slave address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h20;

  // Controller registers on the AHB-Lite side, byte offsets.
  localparam logic [7:0] A_SLAVE = 8'h00;
  localparam logic [7:0] A_REG = 8'h04;
  localparam logic [7:0] A_WDATA = 8'h08;
  localparam logic [7:0] A_GO = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RDATA = 8'h14;
  localparam int GO_WR = 0;
  localparam int GO_RD = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Serial clock timing derived from the system clock.
  localparam int CLK_NS = 50;
  localparam int SCL_NS = 10000;
  localparam int QTR_CYC = SCL_NS / (4 * CLK_NS);
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_AACK = 4'h2,
    D_CMD = 4'h3,
    D_CACK = 4'h4,
    D_WDATA = 4'h5,
    D_WACK = 4'h6,
    D_TX = 4'h7,
    D_MACK = 4'h8,
    D_IGNORE = 4'h9
  } gei_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_FREE = 3'h1,
    H_START = 3'h2,
    H_BIT = 3'h3,
    H_STOP = 3'h4,
    H_GAP = 3'h5
  } gei_hst_t;
endpackage

//--- rtl/gei_if.sv
// Serial link wires between controller and expander, resolved open-drain.
interface gei_if;
  logic hostSclOut;
  logic hostSclOeN;
  logic hostSdaOut;
  logic hostSdaOeN;
  logic devSdaOut;
  logic devSdaOeN;
  logic devIntOut;
  logic devIntOeN;
  logic scl;
  logic sda;
  logic intLine;

  // A released line is pulled high; an enabled driver wins.
  assign scl = hostSclOeN ? 1'b1 : hostSclOut;
  assign sda = (hostSdaOeN ? 1'b1 : hostSdaOut) & (devSdaOeN ? 1'b1 : devSdaOut);
  assign intLine = devIntOeN ? 1'b1 : devIntOut;

  modport dev(input scl, input sda, output devSdaOut, output devSdaOeN,
              output devIntOut, output devIntOeN);
  modport host(input scl, input sda, input intLine, output hostSclOut,
               output hostSclOeN, output hostSdaOut, output hostSdaOeN);
endinterface

//--- rtl/gei_sync.sv
// Two-stage synchroniser with edge detection behind the second stage.
module gei_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
  } gei_sync_t;
  gei_sync_t s_q, s_d;

  always_comb begin
    s_d.ff1 = din;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{ff1: INIT, ff2: INIT, ff3: INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl = s_q.ff2;
  assign rise = s_q.ff2 & ~s_q.ff3;
  assign fall = ~s_q.ff2 & s_q.ff3;
endmodule

//--- rtl/gei_host.sv
// Controller end: AHB-Lite register slave driving Write Byte and Read Byte.
module gei_host
  import gei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  gei_if.host bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef struct packed {
    gei_hst_t st;
    logic [1:0] q;
    logic [5:0] div;
    logic [3:0] bitIdx;
    logic [1:0] step;
    logic isRead;
    logic [7:0] rx;
    logic nack;
    logic [6:0] slv;
    logic [7:0] regIdx;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic sclOeN;
    logic sdaOeN;
    logic aWr;
    logic [7:0] aAddr;
    logic [31:0] hrdata;
  } gei_host_t;
  gei_host_t s_q, s_d;

  logic sclLvl;
  logic sdaLvl;
  logic intLvl;
  logic tick;
  logic rdByte;
  logic [7:0] txb;

  gei_sync #(.W(3), .INIT(3'h7)) lineSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din({bus.intLine, bus.sda, bus.scl}),
    .lvl({intLvl, sdaLvl, sclLvl}),
    .rise(),
    .fall()
  );

  assign tick = s_q.div == QTR_LAST;
  assign rdByte = s_q.step == 2'h3;

  always_comb begin
    if (s_q.step == 2'h0) begin
      txb = {s_q.slv, 1'b0};
    end else if (s_q.step == 2'h1) begin
      txb = s_q.regIdx;
    end else if (s_q.isRead) begin
      txb = {s_q.slv, 1'b1};
    end else begin
      txb = s_q.wdat;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.aWr = 1'b0;
    if (hsel && htrans[1] && hready && hsize == HSIZE_WORD) begin
      s_d.aWr = hwrite;
      s_d.aAddr = haddr[7:0];
      if (haddr[7:0] == A_SLAVE) begin
        s_d.hrdata = {25'h0, s_q.slv};
      end else if (haddr[7:0] == A_REG) begin
        s_d.hrdata = {24'h0, s_q.regIdx};
      end else if (haddr[7:0] == A_WDATA) begin
        s_d.hrdata = {24'h0, s_q.wdat};
      end else if (haddr[7:0] == A_STAT) begin
        s_d.hrdata = {29'h0, ~intLvl, s_q.nack, s_q.st != H_IDLE};
      end else if (haddr[7:0] == A_RDATA) begin
        s_d.hrdata = {24'h0, s_q.rdat};
      end else begin
        s_d.hrdata = 32'h0;
      end
    end
    if (s_q.aWr) begin
      if (s_q.aAddr == A_SLAVE) begin
        s_d.slv = hwdata[6:0];
      end else if (s_q.aAddr == A_REG) begin
        s_d.regIdx = hwdata[7:0];
      end else if (s_q.aAddr == A_WDATA) begin
        s_d.wdat = hwdata[7:0];
      end else if (s_q.aAddr == A_GO && s_q.st == H_IDLE) begin
        if (hwdata[GO_WR] || hwdata[GO_RD]) begin
          s_d.isRead = hwdata[GO_RD];
          s_d.step = 2'h0;
          s_d.nack = 1'b0;
          s_d.st = H_FREE;
        end
      end
    end
    s_d.div = (s_q.st == H_IDLE || s_q.st == H_FREE || tick) ? 6'h00 : s_q.div + 6'h01;
    if (s_q.st == H_FREE) begin
      if (sclLvl && sdaLvl) begin
        s_d.st = H_START;
        s_d.q = 2'h0;
      end
    end else if (s_q.st != H_IDLE && tick) begin
      s_d.q = s_q.q + 2'h1;
      case (s_q.st)
        H_START: begin
          // Also serves as repeated START: SDA is released before SCL rises.
          if (s_q.q == 2'h0) begin
            s_d.sdaOeN = 1'b1;
          end else if (s_q.q == 2'h1) begin
            s_d.sclOeN = 1'b1;
          end else if (s_q.q == 2'h2) begin
            s_d.sdaOeN = 1'b0;
          end else begin
            s_d.sclOeN = 1'b0;
            s_d.bitIdx = 4'h0;
            s_d.st = H_BIT;
          end
        end
        H_BIT: begin
          if (s_q.q == 2'h0) begin
            if (s_q.bitIdx == 4'h8) begin
              s_d.sdaOeN = 1'b1;
            end else begin
              s_d.sdaOeN = rdByte | txb[~s_q.bitIdx[2:0]];
            end
          end else if (s_q.q == 2'h1) begin
            s_d.sclOeN = 1'b1;
          end else if (s_q.q == 2'h2) begin
            if (s_q.bitIdx != 4'h8) begin
              s_d.rx = {s_q.rx[6:0], sdaLvl};
            end else if (!rdByte && sdaLvl) begin
              s_d.nack = 1'b1;
            end
          end else begin
            s_d.sclOeN = 1'b0;
            s_d.bitIdx = s_q.bitIdx + 4'h1;
            if (s_q.bitIdx == 4'h8) begin
              s_d.bitIdx = 4'h0;
              if (s_q.nack || rdByte || (!s_q.isRead && s_q.step == 2'h2)) begin
                s_d.rdat = rdByte ? s_q.rx : s_q.rdat;
                s_d.st = H_STOP;
              end else if (s_q.isRead && s_q.step == 2'h1) begin
                s_d.step = 2'h2;
                s_d.st = H_START;
              end else begin
                s_d.step = s_q.step + 2'h1;
              end
            end
          end
        end
        H_STOP: begin
          if (s_q.q == 2'h0) begin
            s_d.sdaOeN = 1'b0;
          end else if (s_q.q == 2'h1) begin
            s_d.sclOeN = 1'b1;
          end else if (s_q.q == 2'h2) begin
            s_d.sdaOeN = 1'b1;
          end else begin
            s_d.st = H_GAP;
          end
        end
        default: begin
          // Bus free time of four quarters before the next START.
          if (s_q.q == 2'h3) begin
            s_d.st = H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{st: H_IDLE, q: 2'h0, div: 6'h00, bitIdx: 4'h0, step: 2'h0,
               isRead: 1'b0, rx: 8'h00, nack: 1'b0, slv: DEV_ADDR, regIdx: 8'h00,
               wdat: 8'h00, rdat: 8'h00, sclOeN: 1'b1, sdaOeN: 1'b1, aWr: 1'b0,
               aAddr: 8'h00, hrdata: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSclOeN = s_q.sclOeN;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOeN = s_q.sdaOeN;
endmodule

//--- dv/gei_asserts.sv
// Wire-level checks on the serial link between controller and expander.
module gei_asserts
  import gei_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOeN,
  input wire logic devIntOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hiCnt_q;
  logic [7:0] loCnt_q;

  // Saturating counts of consecutive high and low clock-line samples.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hiCnt_q <= 8'h00;
      loCnt_q <= 8'h00;
    end else begin
      hiCnt_q <= !scl ? 8'h00 : (hiCnt_q == 8'hff ? hiCnt_q : hiCnt_q + 8'h01);
      loCnt_q <= scl ? 8'h00 : (loCnt_q == 8'hff ? loCnt_q : loCnt_q + 8'h01);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_dev_sda_hold: assert property (
    scl && $past(scl) |-> $stable(devSdaOeN))
    else $error("device data drive changed while clock high");
  chk_dev_drive_time: assert property (
    $changed(devSdaOeN) |-> !scl && ($past(scl, 2) || $past(scl, 3) || $past(scl, 4)
      || $past(scl, 5) || $past(scl, 6)))
    else $error("device data drive changed away from a clock fall");
  chk_ack_low: assert property (
    $rose(scl) && !devSdaOeN |-> !sda throughout scl [*8])
    else $error("data line not low through acknowledge pulse");
  chk_start_free: assert property (
    $fell(sda) && scl |-> $past(scl, 3) && $past(sda, 3))
    else $error("start issued while bus not free");
  chk_stop_release: assert property (
    $rose(sda) && scl |-> devSdaOeN [*8])
    else $error("device drives data line after stop");
  chk_int_reset: assert property (
    $fell(sys_rst) |-> devIntOeN [*8])
    else $error("interrupt active after reset");
  chk_scl_high: assert property (
    $fell(scl) |-> hiCnt_q >= 8'(2 * QTR_CYC - 1))
    else $error("clock high phase too short");
  chk_scl_low: assert property (
    $rose(scl) && !$past(sys_rst) |-> loCnt_q >= 8'(2 * QTR_CYC - 1))
    else $error("clock low phase too short");

  cov_dev_ack: cover property ($rose(scl) && !devSdaOeN);
  cov_int: cover property ($fell(devIntOeN));
  cov_stop: cover property ($rose(sda) && scl);
endmodule

//--- dv/gpio_expander_i2c_interrupt_tb.sv
// Self-checking bench: controller and expander joined over the serial link.
module gpio_expander_i2c_interrupt_tb
  import gei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] pinIn = 8'h00;
  logic [7:0] pinOut;
  logic [7:0] pinOeN;
  logic standby;
  logic rdTake = 1'b0;
  logic [31:0] rdData;
  logic [31:0] seed = 32'h9b5e9235;
  logic [31:0] expQ[$];
  int n_mismatch = 0;
  int n_tests = 0;

  always #25 clk_sys = ~clk_sys;

  gei_if gei_if_i();
  gei_dev gei_dev_i(.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(gei_if_i), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeN(pinOeN), .standby(standby));
  gei_host gei_host_i(.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(gei_if_i), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  gei_asserts gei_asserts_i(.clk_sys(clk_sys), .sys_rst(sys_rst), .scl(gei_if_i.scl),
    .sda(gei_if_i.sda), .devSdaOeN(gei_if_i.devSdaOeN), .devIntOeN(gei_if_i.devIntOeN));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read data is compared at the edge that ends the data phase.
  always @(posedge clk_sys) begin
    if (rdTake && hreadyout === 1'b1 && expQ.size() > 0) begin
      check(hrdata, expQ.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
  end

  task automatic tick_rdy();
    int n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // One single-word transfer; entered just after a rising edge.
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic chk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    tick_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdTake <= chk;
    tick_rdy();
    rdData = hrdata;
    rdTake <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    ahb(a, 1'b0, 32'h0, 1'b1);
  endtask

  task automatic idle_wait();
    int n = 0;
    do begin
      ahb(A_STAT, 1'b0, 32'h0, 1'b0);
      n++;
    end while (rdData[0] !== 1'b0 && n < 4000);
    if (rdData[0] !== 1'b0) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic go(input logic [7:0] r, input logic [7:0] d, input int op);
    ahb(A_REG, 1'b1, {24'h0, r}, 1'b0);
    ahb(A_WDATA, 1'b1, {24'h0, d}, 1'b0);
    ahb(A_GO, 1'b1, 32'h1 << op, 1'b0);
    repeat (300) @(posedge clk_sys);
    check({31'h0, standby}, 32'h0);
    idle_wait();
    check({31'h0, standby}, 32'h1);
  endtask

  task automatic dev_rd(input logic [7:0] r, input logic [7:0] exp);
    go(r, 8'h00, GO_RD);
    rd_chk(A_RDATA, {24'h0, exp});
  endtask

  task automatic pin_int(input logic [7:0] p, input logic act);
    pinIn <= p;
    repeat (10) @(posedge clk_sys);
    check({31'h0, gei_if_i.intLine}, {31'h0, ~act});
  endtask

  initial begin
    repeat (95000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [7:0] p;
    logic [7:0] r;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    seed = xs(seed);
    p = seed[7:0];
    seed = xs(seed);
    r = seed[7:0];
    pinIn <= p;
    repeat (5) @(posedge clk_sys);
    rd_chk(A_SLAVE, {25'h0, DEV_ADDR});
    rd_chk(8'h1c, 32'h0);
    check({16'h0, pinOut, pinOeN}, {16'h0, OUT_RST, CFG_RST});
    dev_rd(REG_CFG, CFG_RST);
    dev_rd(REG_MASK, MASK_RST);
    dev_rd(REG_IN, p);
    go(REG_OUT, r, GO_WR);
    check({24'h0, pinOut}, {24'h0, r});
    go(REG_MASK, 8'hf7, GO_WR);
    pin_int(p, 1'b0);
    pin_int(p ^ 8'h09, 1'b1);
    dev_rd(REG_STAT, 8'h08);
    dev_rd(REG_OUT, r);
    pin_int(p ^ 8'h09, 1'b1);
    pin_int(p ^ 8'h01, 1'b0);
    pin_int(p ^ 8'h09, 1'b1);
    dev_rd(REG_IN, p ^ 8'h09);
    pin_int(p ^ 8'h09, 1'b0);
    pin_int(p ^ 8'h01, 1'b1);
    go(REG_CFG, 8'hf7, GO_WR);
    check({24'h0, pinOeN}, 32'h0f7);
    pin_int(p ^ 8'h01, 1'b0);
    // Turning the pin back into an input while it differs from the image raises a false alert.
    go(REG_CFG, 8'hff, GO_WR);
    pin_int(p ^ 8'h01, 1'b1);
    ahb(A_SLAVE, 1'b1, {25'h0, DEV_ADDR ^ 7'h01}, 1'b0);
    go(REG_OUT, ~r, GO_WR);
    ahb(A_STAT, 1'b0, 32'h0, 1'b0);
    check(rdData & 32'h2, 32'h2);
    check(rdData & 32'h4, 32'h4);
    check({24'h0, pinOut}, {24'h0, r});
    final_report();
  end
endmodule
